// ---- hw/tcs_dly.v ----
// Persistence timer: output rises after a continuous condition lasts N cycles
`timescale 1ns/1ps
module tcs_dly #(
    parameter CW = 32
) (
    // Clock and reset
    input  wire          i_clk,
    input  wire          i_rstn,
    // Condition and delay
    input  wire          i_cond,
    input  wire [CW-1:0] i_cycles,
    output wire          o_alarm
);
    reg [CW-1:0] cnt_ff;   // Elapsed cycles of the condition
    reg          alarm_ff; // Delayed alarm
    // Count while the condition holds; restart on any gap
    always @(posedge i_clk) begin
        if (!i_rstn || !i_cond) begin
            cnt_ff   <= {CW{1'b0}};
            alarm_ff <= 1'b0;
        end else if (cnt_ff + 1'b1 >= i_cycles) begin
            alarm_ff <= 1'b1;
        end else begin
            cnt_ff   <= cnt_ff + 1'b1;
        end
    end
    assign o_alarm = alarm_ff;
endmodule // tcs_dly

// ---- hw/tcs_map.vh ----
// Constants for the tapchanger supervision block
`ifndef TCS_MAP_VH
`define TCS_MAP_VH
`define TCS_ALARM_MS        32'd30000
`define TCS_RUNAWAY_MS      32'd2000
`define TCS_INCOMPLETE_MS   32'd15000
`define TCS_SCHEME_BASIC    1'b0
`define TCS_SCHEME_STEP     1'b1
`define TCS_ST_IDLE         2'h0
`define TCS_ST_WAIT_RUN     2'h1
`define TCS_ST_RUN          2'h2
`define TCS_ST_DONE         2'h3
`endif

// ---- hw/tcs_sync.v ----
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module tcs_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_rstn,
    // Data
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_ff; // First stage, read only by second stage
    reg [W-1:0] q_ff;    // Second stage
    // Resynchronise to the system clock
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            meta_ff <= {W{1'b0}};
            q_ff    <= {W{1'b0}};
        end else begin
            meta_ff <= i_d;
            q_ff    <= meta_ff;
        end
    end
    assign o_q = q_ff;
endmodule // tcs_sync

// ---- hw/tcs_top.v ----
// Tapchanger supervision: runaway, blocking, inhibit, alarms, step-by-step
`timescale 1ns/1ps
`include "tcs_map.vh"
module tcs_top #(
    parameter CLK_KHZ       = 100000,
    parameter ALARM_MS      = `TCS_ALARM_MS,
    parameter RUNAWAY_MS    = `TCS_RUNAWAY_MS,
    parameter INCOMPLETE_MS = `TCS_INCOMPLETE_MS
) (
    // Clock and reset
    input  wire I_CLK_SYS,
    input  wire I_RSTN,
    // Requests from control sources
    input  wire I_AUTO_RAISE,
    input  wire I_AUTO_LOWER,
    input  wire I_MAN_RAISE,
    input  wire I_MAN_LOWER,
    // Tapchanger pins
    input  wire I_IN_PROGRESS,
    input  wire I_MOTOR_CUR,
    input  wire I_TAP_STEP,
    input  wire I_EXT_BLOCK,
    // Measurement comparator flags, same clock
    input  wire I_OVERCURRENT,
    input  wire I_REVERSE_CUR,
    input  wire I_VOLT_HIGH,
    input  wire I_VOLT_LOW,
    input  wire I_LOW_VOLT_INH,
    input  wire I_PHASE_IMBAL,
    input  wire I_NO_PHASE_REF,
    input  wire I_OUT_OF_BAND,
    input  wire I_AT_TOP_TAP,
    input  wire I_AT_BOTTOM_TAP,
    input  wire I_FOLLOWER_MISMATCH,
    // Configuration
    input  wire I_CFG_STEP_SCHEME,
    input  wire I_CFG_MOTOR_SENSE_EN,
    input  wire I_CFG_LOCKOUT_EN,
    input  wire I_CFG_BREAKER_TRIP_EN,
    input  wire I_CFG_EXT_BLOCK_EN,
    input  wire I_CFG_3PH_VT,
    input  wire I_CFG_MASTER,
    input  wire I_LOCKOUT_CLR,
    // Commands to contactors
    output wire O_RAISE_CMD,
    output wire O_LOWER_CMD,
    output wire O_BLOCK_RAISE_N,
    output wire O_BLOCK_LOWER_N,
    output wire O_LOCKOUT,
    output wire O_BREAKER_TRIP,
    // Alarms
    output wire O_ALM_RUNAWAY,
    output wire O_ALM_INCOMPLETE,
    output wire O_ALM_FUSE,
    output wire O_ALM_TOP,
    output wire O_ALM_BOTTOM,
    output wire O_ALM_NOT_ACHIEVABLE,
    output wire O_ALM_OVERLOAD,
    output wire O_ALM_REVERSE,
    output wire O_ALM_VHIGH,
    output wire O_ALM_VLOW,
    output wire O_ALM_PHASE_REF,
    output wire O_ALM_OUT_OF_BAND,
    output wire O_ALM_OUT_OF_STEP,
    output wire O_ALM_UNCORRECTABLE
);

    ////////////////////////////////////////////////////////////////////////////
    // Timing counts derived from the clock rate
    // Each product must stay below 2**32 at the chosen clock rate
    localparam [31:0] ALARM_CYC = ALARM_MS * CLK_KHZ;        // Longest: exact product, no rounding
    localparam [31:0] RUNAW_CYC = RUNAWAY_MS * CLK_KHZ;      // Tap settle window
    localparam [31:0] INCMP_CYC = INCOMPLETE_MS * CLK_KHZ;   // Longest motor run

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Pins are asynchronous, so two flops guard against metastability
    wire [3:0] pin_s;   // Synchronised pin group
    tcs_sync #(.W(4)) u_sync (
        .i_clk  (I_CLK_SYS),
        .i_rstn (I_RSTN),
        .i_d    ({I_IN_PROGRESS, I_MOTOR_CUR, I_TAP_STEP, I_EXT_BLOCK}),
        .o_q    (pin_s)
    );
    wire in_prog_s = pin_s[3];  // In-progress switch
    wire motor_s   = pin_s[2];  // Motor current sense
    wire step_s    = pin_s[1];  // Tap position changed pulse level
    wire ext_blk_s = pin_s[0];  // External block
    reg  step_d_ff;             // Previous step level for edge detect
    wire step_edge = step_s & ~step_d_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Run indication: motor sense wins when fitted
    // The in-progress switch can stick or chatter; motor current is harder to fake
    wire running = I_CFG_MOTOR_SENSE_EN ? motor_s : in_prog_s;

    ////////////////////////////////////////////////////////////////////////////
    // Blocking and inhibit
    // Kept combinational so a new block opens the contacts without delay
    wire fuse_cond  = I_CFG_3PH_VT & I_PHASE_IMBAL;
    wire ext_blk    = I_CFG_EXT_BLOCK_EN & ext_blk_s;
    wire lock_blk;                                                // Lockout holds block
    wire blk_both   = I_OVERCURRENT | I_REVERSE_CUR | I_NO_PHASE_REF
                    | ext_blk | lock_blk;
    wire blk_raise  = blk_both | I_VOLT_HIGH | fuse_cond | I_AT_TOP_TAP;
    wire blk_lower  = blk_both | I_VOLT_LOW | I_AT_BOTTOM_TAP;
    // Out of step inhibits master auto only; neither blocks manual
    wire auto_inh   = I_LOW_VOLT_INH | (I_CFG_MASTER & I_FOLLOWER_MISMATCH);
    wire uncorr     = I_AT_TOP_TAP | I_AT_BOTTOM_TAP | lock_blk;  // Cannot correct voltage

    // Requests after inhibit; auto also stops while lockout blocks
    wire auto_ok    = ~auto_inh & ~lock_blk;
    wire req_raise  = (I_AUTO_RAISE & auto_ok) | I_MAN_RAISE;
    wire req_lower  = (I_AUTO_LOWER & auto_ok) | I_MAN_LOWER;
    wire go_raise   = req_raise & ~req_lower & ~blk_raise;
    wire go_lower   = req_lower & ~req_raise & ~blk_lower;

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer
    // One command in flight at a time; requests outside IDLE are ignored
    reg  [1:0]  st_ff;          // Sequencer state
    reg  [1:0]  nxt_st;
    reg         dir_ff;         // 1 = raise
    reg         nxt_dir;
    reg  [31:0] tmr_ff;         // Phase timer
    reg  [31:0] nxt_tmr;
    reg  [1:0]  steps_ff;       // Tap steps seen for this command
    reg  [1:0]  nxt_steps;
    reg         runaway_ff;     // Runaway latch
    reg         incmp_ff;       // Incomplete latch
    reg         nxt_runaway;
    reg         nxt_incmp;
    reg         cmd_r_ff;       // Raise command output
    reg         cmd_l_ff;       // Lower command output
    reg         nxt_cmd_r;
    reg         nxt_cmd_l;

    // Request still held (step-by-step only releases after removal)
    wire held = dir_ff ? req_raise : req_lower;

    // Next-state logic
    always @* begin
        nxt_st      = st_ff;
        nxt_dir     = dir_ff;
        nxt_tmr     = tmr_ff + 32'h1;
        nxt_steps   = steps_ff;
        // Clear first, so a fault in the clearing cycle still latches
        nxt_runaway = runaway_ff & ~I_LOCKOUT_CLR;
        nxt_incmp   = incmp_ff & ~I_LOCKOUT_CLR;
        nxt_cmd_r   = 1'b0;
        nxt_cmd_l   = 1'b0;
        // Count tap steps; more than one per command is a runaway
        if (step_edge && steps_ff != 2'h3) begin
            nxt_steps = steps_ff + 2'h1;
        end
        if (step_edge && steps_ff != 2'h0) begin
            nxt_runaway = 1'b1;
        end
        case (st_ff)
            `TCS_ST_IDLE: begin
                nxt_steps = 2'h0;
                nxt_tmr   = 32'h0;
                if (step_edge) begin
                    nxt_runaway = 1'b1;   // Tap moved with no command
                end
                if (go_raise | go_lower) begin
                    nxt_dir   = go_raise;
                    nxt_cmd_r = go_raise;
                    nxt_cmd_l = go_lower;
                    nxt_st    = `TCS_ST_WAIT_RUN;
                end
            end
            `TCS_ST_WAIT_RUN: begin
                // Pulse in basic mode; scheme latches once running
                nxt_cmd_r = dir_ff & I_CFG_STEP_SCHEME & held & ~blk_raise;
                nxt_cmd_l = ~dir_ff & I_CFG_STEP_SCHEME & held & ~blk_lower;
                if (running) begin
                    nxt_tmr = 32'h0;
                    nxt_st  = `TCS_ST_RUN;
                end else if (tmr_ff >= INCMP_CYC) begin
                    nxt_incmp = 1'b1;
                    nxt_st    = `TCS_ST_DONE;
                end
            end
            `TCS_ST_RUN: begin
                // Step-by-step maintains command while motor runs
                // A block during the run drops the maintaining command too
                nxt_cmd_r = dir_ff & I_CFG_STEP_SCHEME & ~blk_raise;
                nxt_cmd_l = ~dir_ff & I_CFG_STEP_SCHEME & ~blk_lower;
                if (tmr_ff >= INCMP_CYC) begin
                    nxt_incmp = 1'b1;
                    nxt_st    = `TCS_ST_DONE;
                end else if (!running) begin
                    nxt_tmr = 32'h0;
                    nxt_st  = `TCS_ST_DONE;
                end
            end
            `TCS_ST_DONE: begin
                // Settle window catches late extra steps
                if (running && tmr_ff < RUNAW_CYC) begin
                    nxt_runaway = 1'b1;
                end
                if (tmr_ff >= RUNAW_CYC) begin
                    // Step-by-step ignores commands until request removed
                    if (!I_CFG_STEP_SCHEME || !held) begin
                        nxt_st = `TCS_ST_IDLE;
                    end
                end
            end
            default: nxt_st = `TCS_ST_IDLE;
        endcase
    end

    // State registers
    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            st_ff      <= `TCS_ST_IDLE;
            dir_ff     <= 1'b0;
            tmr_ff     <= 32'h0;
            steps_ff   <= 2'h0;
            runaway_ff <= 1'b0;
            incmp_ff   <= 1'b0;
            cmd_r_ff   <= 1'b0;
            cmd_l_ff   <= 1'b0;
            step_d_ff  <= 1'b0;
        end else begin
            st_ff      <= nxt_st;
            dir_ff     <= nxt_dir;
            tmr_ff     <= nxt_tmr;
            steps_ff   <= nxt_steps;
            runaway_ff <= nxt_runaway;
            incmp_ff   <= nxt_incmp;
            cmd_r_ff   <= nxt_cmd_r;
            cmd_l_ff   <= nxt_cmd_l;
            step_d_ff  <= step_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lockout and trip
    // Lockout follows the fault latches, so it lasts until an explicit clear
    wire fault = runaway_ff | incmp_ff;
    assign lock_blk       = I_CFG_LOCKOUT_EN & fault;
    reg    trip_ff;         // Breaker trip output
    reg    lock_ff;         // Lockout output
    reg    na_ff;           // Target not achievable
    // Registered outputs for trip, lockout, not-achievable
    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            trip_ff <= 1'b0;
            lock_ff <= 1'b0;
            na_ff   <= 1'b0;
        end else begin
            lock_ff <= lock_blk;
            trip_ff <= I_CFG_BREAKER_TRIP_EN & lock_blk;
            na_ff   <= (req_raise & I_AT_TOP_TAP)
                     | (req_lower & I_AT_BOTTOM_TAP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delayed alarms, one persistence timer each
    // Separate timers, so one condition cannot mask another
    localparam NDLY = 8;
    wire [NDLY-1:0] dly_cond = {uncorr, I_CFG_MASTER & I_FOLLOWER_MISMATCH, I_OUT_OF_BAND,
                                I_NO_PHASE_REF, I_VOLT_LOW, I_VOLT_HIGH,
                                I_REVERSE_CUR, I_OVERCURRENT};
    wire [NDLY-1:0] dly_alm;   // Delayed alarm outputs
    genvar gi;
    generate
        for (gi = 0; gi < NDLY; gi = gi + 1) begin : g_dly
            tcs_dly #(.CW(32)) u_dly (
                .i_clk    (I_CLK_SYS),
                .i_rstn   (I_RSTN),
                .i_cond   (dly_cond[gi]),
                .i_cycles (ALARM_CYC),
                .o_alarm  (dly_alm[gi])
            );
        end
    endgenerate

    // Immediate alarms registered one cycle
    // One flop keeps these alarms glitch-free, at the cost of a cycle
    reg [2:0] imm_ff;   // Fuse, top, bottom
    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            imm_ff <= 3'h0;
        end else begin
            imm_ff <= {fuse_cond, I_AT_TOP_TAP, I_AT_BOTTOM_TAP};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output drive
    assign O_RAISE_CMD          = cmd_r_ff;
    assign O_LOWER_CMD          = cmd_l_ff;
    assign O_BLOCK_RAISE_N      = ~blk_raise;   // Contact open while blocked
    assign O_BLOCK_LOWER_N      = ~blk_lower;
    assign O_LOCKOUT            = lock_ff;
    assign O_BREAKER_TRIP       = trip_ff;
    assign O_ALM_RUNAWAY        = runaway_ff;
    assign O_ALM_INCOMPLETE     = incmp_ff;
    assign O_ALM_FUSE           = imm_ff[2];
    assign O_ALM_TOP            = imm_ff[1];
    assign O_ALM_BOTTOM         = imm_ff[0];
    assign O_ALM_NOT_ACHIEVABLE = na_ff;
    assign O_ALM_OVERLOAD       = dly_alm[0];
    assign O_ALM_REVERSE        = dly_alm[1];
    assign O_ALM_VHIGH          = dly_alm[2];
    assign O_ALM_VLOW           = dly_alm[3];
    assign O_ALM_PHASE_REF      = dly_alm[4];
    assign O_ALM_OUT_OF_BAND    = dly_alm[5];
    assign O_ALM_OUT_OF_STEP    = dly_alm[6];
    assign O_ALM_UNCORRECTABLE  = dly_alm[7];

endmodule // tcs_top

// ---- verif/tcs_motor_model.sv ----
// Behavioural contactor, motor and in-progress switch of the tapchanger
`timescale 1ns/1ps
module tcs_motor_model (
    // Clock
    input  wire       i_clk,
    // Contactor coils
    input  wire       i_raise,
    input  wire       i_lower,
    // Fault to act out: 0 none, 1 taps twice, 2 never starts, 3 switch stuck open
    input  wire [1:0] i_fault,
    // Switch, motor current and tap step pins
    output reg        o_in_progress = 1'b0,
    output reg        o_motor_cur   = 1'b0,
    output reg        o_tap_step    = 1'b0
);
    reg [4:0] run_ff = 5'h00;  // Cycles left in the current run
    reg       cmd_ff = 1'b0;   // Coil state last cycle
    ////////////////////////////////////////////////////////////////////////////
    // A new run starts on a coil edge only, so a held coil cannot retrigger
    always @(posedge i_clk) begin
        cmd_ff <= i_raise | i_lower;
        if (run_ff != 5'h00) begin
            run_ff <= run_ff - 5'h01;  // Switch seals the contactor
        end else if ((i_raise | i_lower) && !cmd_ff && i_fault != 2'h2) begin
            run_ff <= (i_fault == 2'h1) ? 5'h10 : 5'h08;
        end
        o_in_progress <= run_ff != 5'h00 && i_fault != 2'h3;  // Switch closed while running
        o_motor_cur   <= run_ff != 5'h00;
        o_tap_step    <= run_ff[2];  // One step per eight cycles of run
    end
endmodule // tcs_motor_model

// ---- verif/tcs_top_asserts.sv ----
// Concurrent checks on the tapchanger supervision top-level ports
`timescale 1ns/1ps
module tcs_top_chk #(
    parameter CLK_KHZ  = 1,
    parameter ALARM_MS = 20
) (
    // Clock and reset
    input wire I_CLK_SYS,
    input wire I_RSTN,
    // Requests, flags and configuration
    input wire I_MAN_RAISE,
    input wire I_LOW_VOLT_INH,
    input wire I_OVERCURRENT,
    input wire I_REVERSE_CUR,
    input wire I_NO_PHASE_REF,
    input wire I_VOLT_HIGH,
    input wire I_VOLT_LOW,
    input wire I_PHASE_IMBAL,
    input wire I_AT_TOP_TAP,
    input wire I_CFG_3PH_VT,
    input wire I_CFG_STEP_SCHEME,
    input wire I_CFG_LOCKOUT_EN,
    // Outputs watched
    input wire O_RAISE_CMD,
    input wire O_BLOCK_RAISE_N,
    input wire O_BLOCK_LOWER_N,
    input wire O_LOCKOUT,
    input wire O_ALM_RUNAWAY,
    input wire O_ALM_FUSE,
    input wire O_ALM_TOP,
    input wire O_ALM_OVERLOAD
);
    localparam int ALARM_CYC = CLK_KHZ * ALARM_MS;  // Alarm delay in clock cycles
    reg [15:0] oc_cnt;  // Consecutive cycles of overcurrent seen
    ////////////////////////////////////////////////////////////////////////////
    // Persistence counter, restarts on any gap; the delay checks allow two cycles either way
    always @(posedge I_CLK_SYS) begin
        oc_cnt <= (!I_RSTN || !I_OVERCURRENT) ? 16'h0 : oc_cnt + 16'h1;
    end
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);
    ////////////////////////////////////////////////////////////////////////////
    property p_both_blk;
        I_OVERCURRENT || I_REVERSE_CUR || I_NO_PHASE_REF |-> !O_BLOCK_RAISE_N && !O_BLOCK_LOWER_N;
    endproperty
    a_both_blk: assert property (p_both_blk) else $error("both directions not blocked");
    property p_vhigh_blk;
        I_VOLT_HIGH |-> !O_BLOCK_RAISE_N;
    endproperty
    a_vhigh_blk: assert property (p_vhigh_blk) else $error("raise not blocked on high volts");
    property p_vlow_blk;
        I_VOLT_LOW |-> !O_BLOCK_LOWER_N;
    endproperty
    a_vlow_blk: assert property (p_vlow_blk) else $error("lower not blocked on low volts");
    property p_fuse;
        I_CFG_3PH_VT && I_PHASE_IMBAL |-> !O_BLOCK_RAISE_N ##1 O_ALM_FUSE;
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse failure not handled");
    property p_top;
        I_AT_TOP_TAP |-> !O_BLOCK_RAISE_N ##1 O_ALM_TOP;
    endproperty
    a_top: assert property (p_top) else $error("top tap not handled");
    property p_ovl_early;
        O_ALM_OVERLOAD |-> oc_cnt >= ALARM_CYC - 2;
    endproperty
    a_ovl_early: assert property (p_ovl_early) else $error("overload alarm too early");
    property p_ovl_late;
        oc_cnt >= ALARM_CYC + 2 |-> O_ALM_OVERLOAD;
    endproperty
    a_ovl_late: assert property (p_ovl_late) else $error("overload alarm missing");
    property p_cmd_unblk;
        $rose(O_RAISE_CMD) |-> $past(O_BLOCK_RAISE_N);
    endproperty
    a_cmd_unblk: assert property (p_cmd_unblk) else $error("raise issued while blocked");
    property p_inh_auto;
        $rose(O_RAISE_CMD) && $past(I_LOW_VOLT_INH) |-> $past(I_MAN_RAISE);
    endproperty
    a_inh_auto: assert property (p_inh_auto) else $error("auto raise while inhibited");
    property p_pulse;
        !I_CFG_STEP_SCHEME && $rose(O_RAISE_CMD) |=> !O_RAISE_CMD;
    endproperty
    a_pulse: assert property (p_pulse) else $error("basic command not a pulse");
    property p_lockout;
        I_CFG_LOCKOUT_EN && $rose(O_ALM_RUNAWAY) |-> ##[0:2] O_LOCKOUT;
    endproperty
    a_lockout: assert property (p_lockout) else $error("no lockout on runaway");
    c_runaway: cover property ($rose(O_ALM_RUNAWAY));
    c_overload: cover property ($rose(O_ALM_OVERLOAD));
    c_step: cover property (I_CFG_STEP_SCHEME && $rose(O_RAISE_CMD));
endmodule // tcs_top_chk
bind tcs_top tcs_top_chk #(.CLK_KHZ(CLK_KHZ), .ALARM_MS(ALARM_MS)) u_chk (.*);

// ---- verif/test_tapchanger_supervision.sv ----
// Self-checking bench for the tapchanger supervision block
`timescale 1ns/1ps
module test_tapchanger_supervision;
    localparam int AC = 20;  // Alarm delay in cycles at the short sim setting
    logic I_CLK_SYS = 1'b0;
    logic I_RSTN, I_AUTO_RAISE, I_AUTO_LOWER, I_MAN_RAISE, I_MAN_LOWER, I_EXT_BLOCK;
    logic I_OVERCURRENT, I_REVERSE_CUR, I_VOLT_HIGH, I_VOLT_LOW, I_LOW_VOLT_INH, I_PHASE_IMBAL;
    logic I_NO_PHASE_REF, I_OUT_OF_BAND, I_AT_TOP_TAP, I_AT_BOTTOM_TAP, I_FOLLOWER_MISMATCH;
    logic I_CFG_STEP_SCHEME, I_CFG_MOTOR_SENSE_EN, I_CFG_LOCKOUT_EN, I_CFG_BREAKER_TRIP_EN;
    logic I_CFG_EXT_BLOCK_EN, I_CFG_3PH_VT, I_CFG_MASTER, I_LOCKOUT_CLR;
    wire  I_IN_PROGRESS, I_MOTOR_CUR, I_TAP_STEP;
    wire  O_RAISE_CMD, O_LOWER_CMD, O_BLOCK_RAISE_N, O_BLOCK_LOWER_N, O_LOCKOUT, O_BREAKER_TRIP;
    wire  O_ALM_RUNAWAY, O_ALM_INCOMPLETE, O_ALM_FUSE, O_ALM_TOP, O_ALM_BOTTOM;
    wire  O_ALM_NOT_ACHIEVABLE, O_ALM_OVERLOAD, O_ALM_REVERSE, O_ALM_VHIGH, O_ALM_VLOW;
    wire  O_ALM_PHASE_REF, O_ALM_OUT_OF_BAND, O_ALM_OUT_OF_STEP, O_ALM_UNCORRECTABLE;
    logic [1:0] fault = 2'h0;  // Fault the motor model acts out
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         k;
    wire  [3:0] blk_alm = {O_ALM_OVERLOAD, O_ALM_REVERSE, O_ALM_PHASE_REF, 1'b0};
    wire  [4:0] imm_alm = {2'b00, O_ALM_TOP, O_ALM_BOTTOM, O_ALM_FUSE};
    tcs_top #(.CLK_KHZ(1), .ALARM_MS(AC), .RUNAWAY_MS(5), .INCOMPLETE_MS(50)) i_tcs_top (.*);
    tcs_motor_model i_tcs_motor_model (.i_clk(I_CLK_SYS), .i_raise(O_RAISE_CMD),
        .i_lower(O_LOWER_CMD), .i_fault(fault), .o_in_progress(I_IN_PROGRESS),
        .o_motor_cur(I_MOTOR_CUR), .o_tap_step(I_TAP_STEP));
    always #5 I_CLK_SYS = ~I_CLK_SYS;
    ////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t compare %0d saw %h", $time, cmp_count, s);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge I_CLK_SYS);
    endtask
    task tap(input logic [1:0] f, input int n);  // Manual raise pulse, then wait
        fault = f;
        I_MAN_RAISE = 1'b1;
        cyc(1);
        I_MAN_RAISE = 1'b0;
        cyc(n);
        fault = 2'h0;
    endtask
    task clr;
        I_LOCKOUT_CLR = 1'b1;
        cyc(1);
        I_LOCKOUT_CLR = 1'b0;
        cyc(3);
    endtask
    task test_done;
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge I_CLK_SYS);
        error_cnt++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {I_RSTN, I_AUTO_RAISE, I_AUTO_LOWER, I_MAN_RAISE, I_MAN_LOWER, I_EXT_BLOCK,
         I_OVERCURRENT, I_REVERSE_CUR, I_VOLT_HIGH, I_VOLT_LOW, I_LOW_VOLT_INH, I_PHASE_IMBAL,
         I_NO_PHASE_REF, I_OUT_OF_BAND, I_AT_TOP_TAP, I_AT_BOTTOM_TAP, I_FOLLOWER_MISMATCH,
         I_CFG_STEP_SCHEME, I_CFG_3PH_VT, I_CFG_MASTER, I_LOCKOUT_CLR} = '0;
        {I_CFG_MOTOR_SENSE_EN, I_CFG_LOCKOUT_EN, I_CFG_BREAKER_TRIP_EN, I_CFG_EXT_BLOCK_EN} = 4'hf;
        cyc(12);
        I_RSTN = 1'b1;
        cyc(3);
        // Clean tap: one pulse, no fault flags
        I_MAN_RAISE = 1'b1;
        cyc(1);
        check(O_RAISE_CMD, 1'b1);
        I_MAN_RAISE = 1'b0;
        cyc(1);
        check(O_RAISE_CMD, 1'b0);
        cyc(40);
        check({O_ALM_RUNAWAY, O_ALM_INCOMPLETE, O_LOCKOUT}, 8'h0);
        // Runaway: two steps for one command
        tap(2'h1, 40);
        check({O_ALM_RUNAWAY, O_LOCKOUT, O_BREAKER_TRIP}, 8'h7);
        check({O_BLOCK_RAISE_N, O_BLOCK_LOWER_N}, 8'h0);
        cyc(AC + 3);
        check(O_ALM_UNCORRECTABLE, 1'b1);
        I_AUTO_LOWER = 1'b1;
        cyc(2);
        check(O_LOWER_CMD, 1'b0);
        I_AUTO_LOWER = 1'b0;
        clr();
        check({O_ALM_RUNAWAY, O_LOCKOUT, O_BREAKER_TRIP, O_ALM_UNCORRECTABLE}, 8'h0);
        // Motor never starts
        tap(2'h2, 70);
        check({O_ALM_INCOMPLETE, O_LOCKOUT}, 8'h3);
        clr();
        // Switch stuck open: motor sense still proves the run
        tap(2'h3, 40);
        check({O_ALM_INCOMPLETE, O_ALM_RUNAWAY}, 8'h0);
        // Switch alone as run indication; lockout, trip and external block disabled
        {I_CFG_MOTOR_SENSE_EN, I_CFG_LOCKOUT_EN, I_CFG_BREAKER_TRIP_EN, I_CFG_EXT_BLOCK_EN} = 4'h0;
        I_EXT_BLOCK = 1'b1;
        tap(2'h3, 70);
        check({O_ALM_INCOMPLETE, O_LOCKOUT, O_BREAKER_TRIP}, 8'h4);
        check({O_BLOCK_RAISE_N, O_BLOCK_LOWER_N}, 8'h3);
        I_EXT_BLOCK = 1'b0;
        clr();
        {I_CFG_MOTOR_SENSE_EN, I_CFG_LOCKOUT_EN, I_CFG_BREAKER_TRIP_EN, I_CFG_EXT_BLOCK_EN} = 4'hf;
        // Both-direction blocks, each with a timer restart
        for (k = 0; k < 4; k++) begin
            {I_OVERCURRENT, I_REVERSE_CUR, I_NO_PHASE_REF, I_EXT_BLOCK} = 4'h1 << k;
            cyc(3);
            check({O_BLOCK_RAISE_N, O_BLOCK_LOWER_N}, 8'h0);
            I_MAN_LOWER = 1'b1;
            cyc(2);
            check(O_LOWER_CMD, 1'b0);
            I_MAN_LOWER = 1'b0;
            cyc(AC - 8);
            {I_OVERCURRENT, I_REVERSE_CUR, I_NO_PHASE_REF, I_EXT_BLOCK} = 4'h0;
            cyc(1);
            {I_OVERCURRENT, I_REVERSE_CUR, I_NO_PHASE_REF, I_EXT_BLOCK} = 4'h1 << k;
            cyc(AC - 4);
            check(blk_alm[k], 1'b0);
            cyc(8);
            check(blk_alm[k], k != 0);
            {I_OVERCURRENT, I_REVERSE_CUR, I_NO_PHASE_REF, I_EXT_BLOCK} = 4'h0;
            cyc(4);
        end
        // One-direction blocks and immediate alarms
        I_CFG_3PH_VT = 1'b1;
        for (k = 0; k < 5; k++) begin
            {I_VOLT_HIGH, I_VOLT_LOW, I_AT_TOP_TAP, I_AT_BOTTOM_TAP, I_PHASE_IMBAL} = 5'h10 >> k;
            {I_MAN_RAISE, I_MAN_LOWER} = (k % 2) ? 2'b01 : 2'b10;
            cyc(2);
            check({O_BLOCK_RAISE_N, O_BLOCK_LOWER_N}, (k % 2) ? 2'b10 : 2'b01);
            check({O_RAISE_CMD, O_LOWER_CMD, O_ALM_NOT_ACHIEVABLE}, k == 2 || k == 3);
            check(imm_alm, (5'h10 >> k) & 5'h07);
            check(O_ALM_UNCORRECTABLE, 1'b0);
            {I_MAN_RAISE, I_MAN_LOWER} = 2'b00;
            cyc(AC + 3);
            check({O_ALM_VHIGH, O_ALM_VLOW, O_ALM_UNCORRECTABLE}, {k == 0, k == 1, k == 2 || k == 3});
            {I_VOLT_HIGH, I_VOLT_LOW, I_AT_TOP_TAP, I_AT_BOTTOM_TAP, I_PHASE_IMBAL} = 5'h00;
            cyc(3);
        end
        // Dead bus inhibits auto only, manual still works
        I_LOW_VOLT_INH = 1'b1;
        I_AUTO_RAISE = 1'b1;
        cyc(3);
        check(O_RAISE_CMD, 1'b0);
        I_AUTO_RAISE = 1'b0;
        I_MAN_RAISE = 1'b1;
        cyc(1);
        check(O_RAISE_CMD, 1'b1);
        I_MAN_RAISE = 1'b0;
        I_LOW_VOLT_INH = 1'b0;
        cyc(40);
        I_AUTO_LOWER = 1'b1;
        cyc(1);
        check(O_LOWER_CMD, 1'b1);
        I_AUTO_LOWER = 1'b0;
        cyc(40);
        // Out of step and out of band alarm without blocking
        {I_CFG_MASTER, I_FOLLOWER_MISMATCH, I_OUT_OF_BAND} = 3'h7;
        cyc(AC + 3);
        check({O_ALM_OUT_OF_STEP, O_ALM_OUT_OF_BAND, O_BLOCK_RAISE_N, O_BLOCK_LOWER_N}, 8'hf);
        I_AUTO_RAISE = 1'b1;
        cyc(3);
        check(O_RAISE_CMD, 1'b0);
        I_AUTO_RAISE = 1'b0;
        {I_CFG_MASTER, I_FOLLOWER_MISMATCH, I_OUT_OF_BAND} = 3'h0;
        cyc(3);
        // Step-by-step: held command, one tap per press
        I_CFG_STEP_SCHEME = 1'b1;
        I_MAN_LOWER = 1'b1;
        cyc(6);
        check(O_LOWER_CMD, 1'b1);
        cyc(40);
        check({O_LOWER_CMD, O_ALM_RUNAWAY}, 8'h0);
        I_MAN_LOWER = 1'b0;
        cyc(10);
        test_done();
    end
endmodule // test_tapchanger_supervision
